//--- verilog/t1_diag_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef T1_DIAG_MAP_SVH
`define T1_DIAG_MAP_SVH

`define T1_LINE_HZ        1544000
`define EIGHTH_SEC_MS     125
`define EIGHTHS_PER_SEC   8
`define LOOP_CODE_SEC     5

`define REG_CTRL          12'h000
`define REG_TIMEOUT       12'h004
`define REG_STATUS        12'h008

`define CTRL_LOCAL        0
`define CTRL_REMOTE       1
`define CTRL_UNFRAMED     2
`define CTRL_D4           3
`define CTRL_PAT_LO       4
`define CTRL_PAT_HI       5
`define CTRL_ERR_INS      6
`define CTRL_RESET        7'h08
`define TIMEOUT_RESET     4'h3
`define TIMEOUT_NEVER     4'h9

`define LOOP_TO_5M        14'h012c
`define LOOP_TO_10M       14'h0258
`define LOOP_TO_15M       14'h0384
`define LOOP_TO_30M       14'h0708
`define LOOP_TO_45M       14'h0a8c
`define LOOP_TO_1H        14'h0e10
`define LOOP_TO_90M       14'h1518
`define LOOP_TO_2H        14'h1c20
`define LOOP_TO_3H        14'h2a30

`endif

//--- verilog/t1_diag_pkg.sv
// Types shared by the loop and pattern diagnostic block
`default_nettype none
package t1_diag_pkg;

  typedef enum logic [1:0] {
    PAT_OFF  = 2'b00,
    PAT_511  = 2'b01,
    PAT_2047 = 2'b10,
    PAT_QUASI_RANDOM_PATTERN = 2'b11
  } pattern_t;

  typedef struct packed {
    logic frameSyncLost;
    logic txClkLost;
    logic frameLost;
    logic aisAlarm;
    logic raiAlarm;
    logic framingBitErr;
    logic excessZeros;
    logic ctrlSlip;
    logic severeErr;
  } framer_status_t;

  typedef struct packed {
    logic lineLoop;
    logic payloadLoop;
    logic deactivate;
  } fdl_cmd_t;

  typedef struct packed {
    logic txBitLamp;
    logic rxBitLamp;
    logic sync_loss_lamp;
    logic alarm_lamp;
    logic errorLamp;
    logic test_lamp;
  } lamps_t;

  typedef struct packed {
    logic local_analog_loop;
    logic remote_digital_loop;
    logic lineLoop;
    logic payloadLoop;
  } loop_ctl_t;

endpackage
`default_nettype wire

//--- verilog/t1_loop_and_bert_diag.sv
// Lamp, loopback and bit error rate test logic of a T1 service unit
//
// Summary of operation
// - Transmit lamp follows sent bit value
// - Bit lamps only in active timeslots
// - Receive lamp follows received bit value
// - Sync-loss lamp lit on lost synchronization
// - Unframed: sync-loss lamp shows transmit clock
// - Alarm lamp blinks half-second on alarms
// - Error lamp on framer or pattern errors
// - Error lamp held while pattern mismatches
// - Error insertion blinks error lamp each second
// - Test lamp cadence depends on test mode
// - Loops start from register or terminal leads
// - Local loop returns terminal data
// - Remote loop commands far unit loopback
// - D4 10000 code for 5s: loop up
// - D4 100 code for 5s: loop down
// - ESF line loop message loops line side
// - ESF payload message loops after framer
// - Universal deactivate clears central-office loops
// - Three selectable patterns, generator and checker
// - Checker reports error-free or bit-error result
// - Error insertion corrupts transmitted pattern bits
// - Pattern runs alongside local or remote loop
// - Loops end after selectable timeout, default 30min
`timescale 1ns/1ps
`include "t1_diag_map.svh"
`default_nettype none
module t1_loop_and_bert_diag #(
  parameter int EIGHTH_LINE_CLKS = `T1_LINE_HZ / 1000 * `EIGHTH_SEC_MS
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic [11:0]                 paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  input  wire logic                        lineClk,
  input  wire logic                        txData,
  input  wire logic                        rxData,
  input  wire logic                        slotActive,
  input  wire logic                        local_loop_request,
  input  wire logic                        remote_loop_request,
  input  wire t1_diag_pkg::framer_status_t framerStatus,
  input  wire t1_diag_pkg::fdl_cmd_t       fdlCmd,
  output var  t1_diag_pkg::lamps_t         lamps,
  output var  t1_diag_pkg::loop_ctl_t      loops,
  output var  logic                        patBit,
  output var  logic                        patValid
);

  localparam int CODE_EIGHTHS = `LOOP_CODE_SEC * `EIGHTHS_PER_SEC;

  function automatic logic feedback(input logic [19:0] s, input t1_diag_pkg::pattern_t sel);
    unique case (sel)
      t1_diag_pkg::PAT_511:  feedback = s[8] ^ s[4];
      t1_diag_pkg::PAT_2047: feedback = s[10] ^ s[8];
      default:               feedback = s[19] ^ s[16];
    endcase
  endfunction

  function automatic logic [2:0] onesOf(input logic [4:0] v);
    onesOf = 3'({2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]} + {2'h0, v[4]});
  endfunction

  // Pin synchronisers
  logic [5:0] sync1_q, sync2_q, sync1_d, sync2_d;
  logic       lineClkPrev_q, lineClkPrev_d;
  logic       lineRise, txS, rxS, slotS, llrS, rlrS;

  always_comb begin
    sync1_d = {lineClk, txData, rxData, slotActive, local_loop_request, remote_loop_request};
    sync2_d = sync1_q;
    lineClkPrev_d = sync2_q[5];
    lineRise = sync2_q[5] & ~lineClkPrev_q;
    {txS, rxS, slotS, llrS, rlrS} = sync2_q[4:0];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      lineClkPrev_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      lineClkPrev_q <= lineClkPrev_d;
    end
  end

  // Line-clock tick timing: eighth-second phase
  logic [17:0] tickCnt_q, tickCnt_d;
  logic [2:0]  phase_q, phase_d;
  logic        eighthTick, secTick;

  always_comb begin
    eighthTick = lineRise && (tickCnt_q == 18'(EIGHTH_LINE_CLKS - 1));
    secTick = eighthTick && (phase_q == 3'h7);
    tickCnt_d = tickCnt_q;
    phase_d = phase_q;
    if (lineRise) begin
      tickCnt_d = eighthTick ? 18'h00000 : tickCnt_q + 18'h00001;
    end
    if (eighthTick) begin
      phase_d = phase_q + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tickCnt_q <= 18'h00000;
      phase_q <= 3'h0;
    end else begin
      tickCnt_q <= tickCnt_d;
      phase_q <= phase_d;
    end
  end

  // Register file over APB
  logic [6:0]  ctrl_q, ctrl_d;
  logic [3:0]  toCode_q, toCode_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic        mapped, commit;
  logic [11:0] status;
  t1_diag_pkg::pattern_t patSel;

  always_comb begin
    mapped = (paddr == `REG_CTRL) || (paddr == `REG_TIMEOUT) || (paddr == `REG_STATUS);
    commit = psel && penable && pready_q;
    ctrl_d = ctrl_q;
    toCode_d = toCode_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = 1'b0;
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
      pslverr_d = !mapped;
      unique case (paddr)
        `REG_CTRL:    prdata_d = {25'h0000000, ctrl_q};
        `REG_TIMEOUT: prdata_d = {28'h0000000, toCode_q};
        `REG_STATUS:  prdata_d = {20'h00000, status};
        default:      prdata_d = 32'h00000000;
      endcase
    end
    if (commit && pwrite && paddr == `REG_CTRL) begin
      ctrl_d = pwdata[6:0];
    end
    if (commit && pwrite && paddr == `REG_TIMEOUT && pwdata[3:0] <= `TIMEOUT_NEVER) begin
      toCode_d = pwdata[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q <= `CTRL_RESET;
      toCode_q <= `TIMEOUT_RESET;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      toCode_q <= toCode_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Pattern generator and checker
  logic [19:0] gen_q, gen_d, chk_q, chk_d;
  logic        insArm_q, insArm_d, errWin_q, errWin_d, patErr_q, patErr_d;
  logic        patBit_q, patBit_d, patValid_q, patValid_d;
  logic        patOn, genFb, genOut, expBit, mismatch;

  always_comb begin
    patSel = t1_diag_pkg::pattern_t'(ctrl_q[`CTRL_PAT_HI:`CTRL_PAT_LO]);
    patOn = patSel != t1_diag_pkg::PAT_OFF;
    genFb = feedback(gen_q, patSel) | (gen_q == 20'h00000);
    genOut = genFb;
    if (patSel == t1_diag_pkg::PAT_QUASI_RANDOM_PATTERN && gen_q[13:0] == 14'h0000) begin
      genOut = 1'b1;
    end
    expBit = feedback(chk_q, patSel);
    mismatch = lineRise && patOn && (rxS != expBit);
    gen_d = gen_q;
    chk_d = chk_q;
    insArm_d = insArm_q;
    patBit_d = patBit_q;
    patValid_d = patOn;
    if (lineRise && patOn) begin
      gen_d = {gen_q[18:0], genFb};
      chk_d = {chk_q[18:0], rxS};
      patBit_d = genOut ^ insArm_q;
      insArm_d = 1'b0;
    end
    if (secTick && ctrl_q[`CTRL_ERR_INS]) begin
      insArm_d = 1'b1;
    end
    if (eighthTick) begin
      patErr_d = errWin_q | mismatch;
      errWin_d = 1'b0;
    end else begin
      patErr_d = patErr_q | mismatch;
      errWin_d = errWin_q | mismatch;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gen_q <= 20'h00001;
      chk_q <= 20'h00000;
      insArm_q <= 1'b0;
      errWin_q <= 1'b0;
      patErr_q <= 1'b0;
      patBit_q <= 1'b0;
      patValid_q <= 1'b0;
    end else begin
      gen_q <= gen_d;
      chk_q <= chk_d;
      insArm_q <= insArm_d;
      errWin_q <= errWin_d;
      patErr_q <= patErr_d;
      patBit_q <= patBit_d;
      patValid_q <= patValid_d;
    end
  end

  // Loopback control, central-office codes and timeout
  logic [5:0]  hist_q, hist_d, upRun_q, upRun_d, dnRun_q, dnRun_d;
  logic [13:0] loopSec_q, loopSec_d, limit;
  logic        coLine_q, coLine_d, coPay_q, coPay_d, timedOut_q, timedOut_d;
  logic        d4Mode, upMatch, dnMatch, upFire, dnFire, localAct, remoteAct;
  logic        anyLoop, toHit;

  always_comb begin
    unique case (toCode_q)
      4'h0:    limit = `LOOP_TO_5M;
      4'h1:    limit = `LOOP_TO_10M;
      4'h2:    limit = `LOOP_TO_15M;
      4'h3:    limit = `LOOP_TO_30M;
      4'h4:    limit = `LOOP_TO_45M;
      4'h5:    limit = `LOOP_TO_1H;
      4'h6:    limit = `LOOP_TO_90M;
      4'h7:    limit = `LOOP_TO_2H;
      default: limit = `LOOP_TO_3H;
    endcase
    d4Mode = ctrl_q[`CTRL_D4];
    upMatch = (hist_q[5] == hist_q[0]) && (onesOf(hist_q[4:0]) == 3'h1);
    dnMatch = (hist_q[3] == hist_q[0]) && (onesOf({2'h0, hist_q[2:0]}) == 3'h1);
    upFire = d4Mode && eighthTick && upMatch && upRun_q == 6'(CODE_EIGHTHS - 1);
    dnFire = d4Mode && eighthTick && dnRun_q == 6'(CODE_EIGHTHS - 1);
    localAct = (ctrl_q[`CTRL_LOCAL] | llrS) & ~timedOut_q;
    remoteAct = (ctrl_q[`CTRL_REMOTE] | rlrS) & ~timedOut_q;
    anyLoop = localAct | remoteAct | coLine_q | coPay_q;
    toHit = anyLoop && secTick && toCode_q != `TIMEOUT_NEVER && loopSec_q + 14'h1 >= limit;
    hist_d = lineRise ? {hist_q[4:0], rxS} : hist_q;
    upRun_d = upRun_q;
    dnRun_d = dnRun_q;
    if (lineRise && !upMatch) begin
      upRun_d = 6'h00;
    end else if (eighthTick && upRun_q != 6'(CODE_EIGHTHS)) begin
      upRun_d = upRun_q + 6'h01;
    end
    if (lineRise && !dnMatch) begin
      dnRun_d = 6'h00;
    end else if (eighthTick && dnRun_q != 6'(CODE_EIGHTHS)) begin
      dnRun_d = dnRun_q + 6'h01;
    end
    loopSec_d = !anyLoop ? 14'h0000 : (secTick ? loopSec_q + 14'h0001 : loopSec_q);
    timedOut_d = timedOut_q;
    if (toHit) begin
      timedOut_d = 1'b1;
    end else if (!(ctrl_q[`CTRL_LOCAL] | llrS | ctrl_q[`CTRL_REMOTE] | rlrS)) begin
      timedOut_d = 1'b0;
    end
    coLine_d = coLine_q;
    coPay_d = coPay_q;
    if (dnFire || fdlCmd.deactivate || toHit) begin
      coLine_d = 1'b0;
      coPay_d = 1'b0;
    end
    if (upFire || (!d4Mode && fdlCmd.lineLoop)) begin
      coLine_d = 1'b1;
    end
    if (!d4Mode && fdlCmd.payloadLoop) begin
      coPay_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hist_q <= 6'h00;
      upRun_q <= 6'h00;
      dnRun_q <= 6'h00;
      loopSec_q <= 14'h0000;
      coLine_q <= 1'b0;
      coPay_q <= 1'b0;
      timedOut_q <= 1'b0;
    end else begin
      hist_q <= hist_d;
      upRun_q <= upRun_d;
      dnRun_q <= dnRun_d;
      loopSec_q <= loopSec_d;
      coLine_q <= coLine_d;
      coPay_q <= coPay_d;
      timedOut_q <= timedOut_d;
    end
  end

  // Lamps and loop outputs
  t1_diag_pkg::lamps_t    lamps_q, lamps_d;
  t1_diag_pkg::loop_ctl_t loops_q, loops_d;
  logic                   anyAlarm, frmErr;

  always_comb begin
    anyAlarm = framerStatus.frameSyncLost | framerStatus.frameLost |
               framerStatus.aisAlarm | framerStatus.raiAlarm;
    frmErr = framerStatus.framingBitErr | framerStatus.excessZeros |
             framerStatus.ctrlSlip | framerStatus.severeErr;
    lamps_d = lamps_q;
    if (lineRise) begin
      lamps_d.txBitLamp = slotS & txS;
      lamps_d.rxBitLamp = slotS & rxS;
    end
    lamps_d.sync_loss_lamp = ctrl_q[`CTRL_UNFRAMED] ? framerStatus.txClkLost
                                                    : framerStatus.frameSyncLost;
    lamps_d.alarm_lamp = anyAlarm & ~phase_q[2];
    lamps_d.errorLamp = frmErr | patErr_q | mismatch;
    if (patOn || remoteAct) begin
      lamps_d.test_lamp = 1'b1;
    end else if (coLine_q || coPay_q) begin
      lamps_d.test_lamp = phase_q != 3'h0;
    end else begin
      lamps_d.test_lamp = localAct && phase_q == 3'h0;
    end
    loops_d.local_analog_loop = localAct;
    loops_d.remote_digital_loop = remoteAct;
    loops_d.lineLoop = coLine_q;
    loops_d.payloadLoop = coPay_q;
    status = {lamps_q, patErr_q, timedOut_q, coPay_q, coLine_q, remoteAct, localAct};
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lamps_q <= '0;
      loops_q <= '0;
    end else begin
      lamps_q <= lamps_d;
      loops_q <= loops_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lamps = lamps_q;
  assign loops = loops_q;
  assign patBit = patBit_q;
  assign patValid = patValid_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_tx_lamp_follow: assert property (lineRise && slotS |=> lamps.txBitLamp == $past(txS))
    else $error("transmit lamp does not follow sent bit");
  a_rx_lamp_follow: assert property (lineRise && slotS |=> lamps.rxBitLamp == $past(rxS))
    else $error("receive lamp does not follow received bit");
  a_idle_slot_dark: assert property (lineRise && !slotS |=> lamps[5:4] == 2'b00)
    else $error("bit lamps lit in inactive timeslot");
  a_sync_lamp_src: assert property (ctrl_q[`CTRL_UNFRAMED] ##1 ctrl_q[`CTRL_UNFRAMED]
      |-> lamps.sync_loss_lamp == $past(framerStatus.txClkLost))
    else $error("unframed sync lamp not from transmit clock");
  a_alarm_quiet: assert property (!anyAlarm |=> !lamps.alarm_lamp)
    else $error("alarm lamp lit without alarm");
  a_pat_err_lamp: assert property (mismatch |=> lamps.errorLamp ##1 patErr_q)
    else $error("pattern mismatch not shown on error lamp");
  a_test_steady: assert property (patOn && $stable(ctrl_q) |=> lamps.test_lamp)
    else $error("test lamp not steady while pattern runs");
  a_loop_down: assert property (dnFire |=> !coLine_q ##1 !loops.lineLoop)
    else $error("loop-down code did not release line loop");
  a_loop_up: assert property (upFire |=> coLine_q ##1 loops.lineLoop)
    else $error("loop-up code did not set line loop");
  a_deact_clear: assert property (fdlCmd.deactivate && !fdlCmd.payloadLoop |=> !coPay_q)
    else $error("deactivate did not clear payload loop");
  a_local_honour: assert property (llrS && !timedOut_q |=> loops.local_analog_loop)
    else $error("local loop lead not honoured");
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("APB access not answered in one wait state");

endmodule
`default_nettype wire

//--- testbench/t1_line_partner.sv
// Line and terminal model: free-running line clock, data bits, loop codes
`timescale 1ns/1ps
`default_nettype none
module t1_line_partner (
  output var  logic       lineClk,
  output var  logic       txData,
  output var  logic       rxData,
  input  wire logic       patBit,
  input  wire logic [2:0] mode,
  input  wire logic       txFix,
  input  wire logic       rxFix
);
  int bitNum;

  // Bits change on the falling line edge, away from the sampling edge
  initial begin
    lineClk = 1'b0;
    txData  = 1'b0;
    rxData  = 1'b0;
    bitNum  = 0;
    forever begin
      #80 lineClk = 1'b1;
      #80 lineClk = 1'b0;
      bitNum = bitNum + 1;
      case (mode)
        3'd1:    rxData = (bitNum % 5 == 0);
        3'd2:    rxData = (bitNum % 3 == 0);
        3'd3:    rxData = patBit;
        3'd4:    rxData = ~patBit;
        default: rxData = rxFix;
      endcase
      txData = (mode == 3'd0) ? txFix : rxData;
    end
  end
endmodule
`default_nettype wire

//--- testbench/t1_loop_and_bert_diag_bench.sv
// Bench for the lamp, loopback and pattern test block
`timescale 1ns/1ps
`include "t1_diag_map.svh"
`default_nettype none
module t1_loop_and_bert_diag_bench;
  logic                        sys_clk;
  logic                        rst_n;
  logic [11:0]                 paddr;
  logic                        psel;
  logic                        penable;
  logic                        pwrite;
  logic [31:0]                 pwdata;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic                        lineClk;
  logic                        txData;
  logic                        rxData;
  logic                        slotActive;
  logic                        local_loop_request;
  logic                        remote_loop_request;
  t1_diag_pkg::framer_status_t framerStatus;
  t1_diag_pkg::fdl_cmd_t       fdlCmd;
  t1_diag_pkg::lamps_t         lamps;
  t1_diag_pkg::loop_ctl_t      loops;
  logic                        patBit;
  logic                        patValid;
  logic [2:0]                  mode;
  logic                        txFix;
  logic                        rxFix;
  int                          errors;
  int                          numChecks;
  logic                        capBits [0:159];
  int                          alarmBit [4] = '{8, 6, 5, 4};

  t1_loop_and_bert_diag #(.EIGHTH_LINE_CLKS(8)) t1_loop_and_bert_diag_i (
    .sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .lineClk, .txData, .rxData, .slotActive, .local_loop_request,
    .remote_loop_request, .framerStatus, .fdlCmd, .lamps, .loops, .patBit, .patValid
  );

  t1_line_partner t1_line_partner_i (
    .lineClk, .txData, .rxData, .patBit, .mode, .txFix, .rxFix
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    numChecks++;
    if (seen !== expv) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && numChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctl(input logic [31:0] v);
    logic [31:0] rd;
    logic        e;
    apb(`REG_CTRL, 1'b1, v, rd, e);
    cyc(4);
  endtask

  task automatic fdl(input logic [2:0] v);
    fdlCmd <= t1_diag_pkg::fdl_cmd_t'(v);
    @(posedge sys_clk);
    fdlCmd <= '0;
    cyc(4);
  endtask

  task automatic count_on(input int idx, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge sys_clk);
      if (lamps[idx] === 1'b1) c++;
    end
  endtask

  // Records generated bits and how many of them saw the error lamp lit
  task automatic capture(input int n, output int errOn);
    errOn = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge lineClk);
      capBits[i] = patBit;
      if (lamps.errorLamp === 1'b1) errOn++;
    end
  endtask

  function automatic int violations(input int a, input int b, input int n);
    int v;
    v = 0;
    for (int i = a; i < n; i++) if (capBits[i] !== (capBits[i-a] ^ capBits[i-b])) v++;
    return v;
  endfunction

  initial begin
    #800000;
    errors++;
    complete_run();
  end

  initial begin
    logic [31:0] rd;
    logic        err;
    int          c;
    int          k;
    int          ones;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slotActive = 1'b0;
    local_loop_request = 1'b0;
    remote_loop_request = 1'b0;
    framerStatus = '0;
    fdlCmd = '0;
    mode = 3'd0;
    txFix = 1'b0;
    rxFix = 1'b0;
    errors = 0;
    numChecks = 0;
    cyc(2);
    rst_n <= 1'b1;
    apb(`REG_CTRL, 1'b0, 32'h0, rd, err);
    check(rd, 32'h8);
    apb(`REG_TIMEOUT, 1'b0, 32'h0, rd, err);
    check(rd, 32'h3);
    apb(`REG_TIMEOUT, 1'b1, 32'ha, rd, err);
    apb(`REG_TIMEOUT, 1'b0, 32'h0, rd, err);
    check(rd, 32'h3);
    apb(`REG_TIMEOUT, 1'b1, 32'h9, rd, err);
    apb(`REG_TIMEOUT, 1'b0, 32'h0, rd, err);
    check(rd, 32'h9);
    apb(12'h00c, 1'b0, 32'h0, rd, err);
    check({rd[30:0], err}, 32'h1);
    slotActive <= 1'b1;
    txFix <= 1'b1;
    cyc(64);
    check(lamps[5:4], 2'b10);
    txFix <= 1'b0;
    rxFix <= 1'b1;
    cyc(64);
    check(lamps[5:4], 2'b01);
    slotActive <= 1'b0;
    cyc(64);
    check(lamps[5:4], 2'b00);
    framerStatus.frameSyncLost <= 1'b1;
    cyc(6);
    check(lamps.sync_loss_lamp, 1'b1);
    ctl(32'h0c);
    check(lamps.sync_loss_lamp, 1'b0);
    framerStatus.txClkLost <= 1'b1;
    cyc(6);
    check(lamps.sync_loss_lamp, 1'b1);
    ctl(32'h08);
    foreach (alarmBit[i]) begin
      framerStatus <= t1_diag_pkg::framer_status_t'(9'h001 << alarmBit[i]);
      cyc(8);
      count_on(2, 1024, c);
      check(c, 512);
    end
    for (k = 0; k < 4; k++) begin
      framerStatus <= t1_diag_pkg::framer_status_t'(9'h001 << k);
      cyc(6);
      check(lamps.errorLamp, 1'b1);
    end
    framerStatus <= '0;
    local_loop_request <= 1'b1;
    cyc(8);
    check(loops, 4'b1000);
    count_on(0, 1024, c);
    check(c, 128);
    local_loop_request <= 1'b0;
    remote_loop_request <= 1'b1;
    cyc(8);
    check(loops, 4'b0100);
    count_on(0, 1024, c);
    check(c, 1024);
    remote_loop_request <= 1'b0;
    ctl(32'h09);
    apb(`REG_STATUS, 1'b0, 32'h0, rd, err);
    check({loops, rd[1:0]}, 6'b100001);
    ctl(32'h08);
    mode <= 3'd1;
    cyc(4096);
    check(loops.lineLoop, 1'b0);
    cyc(2048);
    check(loops.lineLoop, 1'b1);
    count_on(0, 1024, c);
    check(c, 896);
    mode <= 3'd2;
    cyc(6144);
    check(loops.lineLoop, 1'b0);
    mode <= 3'd0;
    ctl(32'h00);
    fdl(3'b100);
    check(loops, 4'b0010);
    fdl(3'b010);
    check(loops, 4'b0011);
    fdl(3'b001);
    check(loops, 4'b0000);
    ctl(32'h08);
    fdl(3'b100);
    check(loops, 4'b0000);
    mode <= 3'd3;
    for (k = 1; k < 4; k++) begin
      ctl(32'h1 | (k << 4));
      cyc(800);
      capture(120, c);
      check({patValid, loops.local_analog_loop, lamps.test_lamp}, 3'b111);
      if (k < 3) begin
        check(violations(k == 1 ? 9 : 11, k == 1 ? 5 : 9, 120), 0);
        apb(`REG_STATUS, 1'b0, 32'h0, rd, err);
        check(rd[5], 1'b0);
        check(c, 0);
      end else begin
        ones = 0;
        for (int i = 0; i < 120; i++) ones += capBits[i];
        check(ones > 0 && ones < 120, 1'b1);
      end
    end
    ctl(32'h20);
    mode <= 3'd4;
    cyc(800);
    apb(`REG_STATUS, 1'b0, 32'h0, rd, err);
    check({lamps.errorLamp, rd[5]}, 2'b11);
    mode <= 3'd3;
    ctl(32'h60);
    cyc(800);
    capture(140, c);
    check(violations(11, 9, 140) > 0, 1'b1);
    check(c > 0 && c < 140, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
